// [rtl/otd_defines.vh]
// Register indices, field positions, reset values and widths of the outside-threshold detector
`ifndef OTD_DEFINES_VH
`define OTD_DEFINES_VH

// Register indices; the byte address on the bus is four times the index
`define OTD_IDX_STATUS 8'h2D
`define OTD_IDX_CONFIG 8'h30
`define OTD_IDX_UPPER 8'h31
`define OTD_IDX_LOWER 8'h32
`define OTD_IDX_DEBOUNCE 8'h33
`define OTD_IDX_SLEEP 8'h34
`define OTD_IDX_IRQ_STAT 8'h35
`define OTD_IDX_IRQ_MASK 8'h36

// Outside-event status byte
`define OTD_ST_ACTIVE 7
`define OTD_ST_X_FLAG 5
`define OTD_ST_X_POL 4
`define OTD_ST_Y_FLAG 3
`define OTD_ST_Y_POL 2
`define OTD_ST_Z_FLAG 1
`define OTD_ST_Z_POL 0

// Configuration register fields
`define OTD_CFG_X_EN 0
`define OTD_CFG_Y_EN 1
`define OTD_CFG_Z_EN 2
`define OTD_CFG_REL 3
`define OTD_CFG_WAKE 4
`define OTD_CFG_PIN_ONE 5
`define OTD_CFG_PIN_TWO 6
`define OTD_CFG_WIDTH 7

// Interrupt status and mask bits
`define OTD_IRQ_RISE 0
`define OTD_IRQ_FALL 1
`define OTD_IRQ_SLEEP 2
`define OTD_IRQ_WAKE 3
`define OTD_IRQ_WIDTH 4

// Reset values
`define OTD_RST_STATUS 8'h00
`define OTD_RST_CONFIG 7'h00
`define OTD_RST_UPPER 12'h7ff
`define OTD_RST_LOWER 12'h800
`define OTD_RST_DEBOUNCE 8'h00
`define OTD_RST_SLEEP 16'h0000
`define OTD_RST_IRQ 4'h0

`endif

// [rtl/otd_axis_cmp.v]
// One axis of the outside-threshold detector: delta, window compare, flag and polarity
`timescale 1ns/10ps
`default_nettype none

module otd_axis_cmp #(
  parameter DATA_WIDTH = 12
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Sample stream
  input wire odrTick,
  input wire [DATA_WIDTH-1:0] sample,
  // Settings
  input wire axisEnable,
  input wire relativeMode,
  input wire [DATA_WIDTH-1:0] upperThreshold,
  input wire [DATA_WIDTH-1:0] lowerThreshold,
  // Results
  output wire outsideNow,
  output wire axisFlag,
  output wire axisPolarity
);

  reg [DATA_WIDTH-1:0] prevSample_reg;
  reg flag_reg;
  reg polarity_reg;

  // One extra bit so the delta of two full-scale samples cannot wrap
  wire signed [DATA_WIDTH:0] curExt = {sample[DATA_WIDTH-1], sample};
  wire signed [DATA_WIDTH:0] prevExt = {prevSample_reg[DATA_WIDTH-1], prevSample_reg};
  wire signed [DATA_WIDTH:0] deltaExt = curExt - prevExt;
  wire signed [DATA_WIDTH:0] value = relativeMode ? deltaExt : curExt;
  wire signed [DATA_WIDTH:0] upperExt = {upperThreshold[DATA_WIDTH-1], upperThreshold};
  wire signed [DATA_WIDTH:0] lowerExt = {lowerThreshold[DATA_WIDTH-1], lowerThreshold};
  wire aboveUpper = (value >= upperExt);
  wire belowLower = (value <= lowerExt);

  // Strictly inside the window leaves the flag low; a disabled axis never raises it
  assign outsideNow = axisEnable & (aboveUpper | belowLower);
  assign axisFlag = flag_reg;
  assign axisPolarity = polarity_reg;

  always @(posedge clk) begin
    if (rst) begin
      prevSample_reg <= {DATA_WIDTH{1'b0}};
      flag_reg <= 1'b0;
      polarity_reg <= 1'b0;
    end else if (odrTick) begin
      prevSample_reg <= sample;
      flag_reg <= outsideNow;
      // Polarity is latched only on the flag's rising sample; upper wins if both bounds are met
      if (outsideNow && !flag_reg) begin
        polarity_reg <= aboveUpper;
      end
    end
  end

endmodule // otd_axis_cmp

`default_nettype wire

// [rtl/otd_outside_detect.v]
// Outside-threshold event detector with debounce, sleep hold-off, interrupts and AHB-Lite registers
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "otd_defines.vh"

module otd_outside_detect #(
  parameter DATA_WIDTH = 12,
  parameter DB_WIDTH = 8,
  parameter SLEEP_WIDTH = 16
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Sample stream, one strobe per output-data-rate period
  input wire odrTick,
  input wire [DATA_WIDTH-1:0] xSample,
  input wire [DATA_WIDTH-1:0] ySample,
  input wire [DATA_WIDTH-1:0] zSample,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  // Event and power outputs
  output wire outsideEventActive,
  output wire interruptPinOne,
  output wire interruptPinTwo,
  output wire sleepMode,
  output wire irq
);

  localparam [DB_WIDTH:0] DB_ONE = {{DB_WIDTH{1'b0}}, 1'b1};
  localparam [SLEEP_WIDTH:0] SLEEP_ONE = {{SLEEP_WIDTH{1'b0}}, 1'b1};

  // Software-visible settings
  reg [`OTD_CFG_WIDTH-1:0] config_reg;
  reg [DATA_WIDTH-1:0] upperThreshold_reg;
  reg [DATA_WIDTH-1:0] lowerThreshold_reg;
  reg [DB_WIDTH-1:0] debounce_reg;
  reg [SLEEP_WIDTH-1:0] sleepCount_reg;
  reg [`OTD_IRQ_WIDTH-1:0] irqStat_reg;
  reg [`OTD_IRQ_WIDTH-1:0] irqStat_next;
  reg [`OTD_IRQ_WIDTH-1:0] irqMask_reg;

  // Detector state
  reg [DB_WIDTH-1:0] dbCount_reg;
  reg active_reg;
  reg activeDly_reg;
  reg [SLEEP_WIDTH-1:0] sleepTimer_reg;
  reg sleep_reg;
  reg sleepDly_reg;
  reg pinOne_reg;
  reg pinTwo_reg;
  reg irq_reg;

  // Bus state
  reg wrPending_reg;
  reg [7:0] wrIndex_reg;
  reg [31:0] hrdata_reg;

  wire [2:0] axisEnable;
  wire [2:0] axisOutside;
  wire [2:0] axisFlag;
  wire [2:0] axisPolarity;
  wire [3*DATA_WIDTH-1:0] sampleBus;

  assign axisEnable = {config_reg[`OTD_CFG_X_EN], config_reg[`OTD_CFG_Y_EN], config_reg[`OTD_CFG_Z_EN]};
  assign sampleBus = {xSample, ySample, zSample};

  // Index 2 is x, 1 is y, 0 is z, matching the order of the status byte
  genvar axis;
  generate
    for (axis = 0; axis < 3; axis = axis + 1) begin : gAxis
      otd_axis_cmp #(
        .DATA_WIDTH(DATA_WIDTH)
      ) uAxis (
        .clk(clk),
        .rst(rst),
        .odrTick(odrTick),
        .sample(sampleBus[axis*DATA_WIDTH +: DATA_WIDTH]),
        .axisEnable(axisEnable[axis]),
        .relativeMode(config_reg[`OTD_CFG_REL]),
        .upperThreshold(upperThreshold_reg),
        .lowerThreshold(lowerThreshold_reg),
        .outsideNow(axisOutside[axis]),
        .axisFlag(axisFlag[axis]),
        .axisPolarity(axisPolarity[axis])
      );
    end
  endgenerate

  // Disabled axes never report outside, so all enables clear keeps the flag low
  wire anyOutside = |axisOutside;
  wire [DB_WIDTH:0] dbCountInc = {1'b0, dbCount_reg} + DB_ONE;
  wire dbReached = (dbCountInc >= {1'b0, debounce_reg});
  wire dbSaturated = &dbCount_reg;

  // Debounce: counts samples with the OR of axis flags true
  always @(posedge clk) begin
    if (rst) begin
      dbCount_reg <= {DB_WIDTH{1'b0}};
      active_reg <= 1'b0;
    end else if (odrTick) begin
      if (anyOutside) begin
        // Saturate so a long event cannot wrap back below the debounce count
        if (!dbSaturated) begin
          dbCount_reg <= dbCountInc[DB_WIDTH-1:0];
        end
        if (dbReached) begin
          active_reg <= 1'b1;
        end
      end else begin
        dbCount_reg <= {DB_WIDTH{1'b0}};
        active_reg <= 1'b0;
      end
    end
  end

  // Automatic wake/sleep timer, counted in sample periods; a count of zero disables sleep
  wire wakeHold = config_reg[`OTD_CFG_WAKE] & active_reg;
  wire [SLEEP_WIDTH:0] sleepTimerInc = {1'b0, sleepTimer_reg} + SLEEP_ONE;
  wire sleepDue = (sleepCount_reg != {SLEEP_WIDTH{1'b0}}) && (sleepTimerInc >= {1'b0, sleepCount_reg});

  always @(posedge clk) begin
    if (rst) begin
      sleepTimer_reg <= {SLEEP_WIDTH{1'b0}};
      sleep_reg <= 1'b0;
    end else if (odrTick) begin
      if (wakeHold) begin
        sleepTimer_reg <= {SLEEP_WIDTH{1'b0}};
        sleep_reg <= 1'b0;
      end else if (!sleep_reg) begin
        if (sleepDue) begin
          // Entry waits for the active flag to drop; the timer stays at its limit meanwhile
          if (!active_reg) begin
            sleep_reg <= 1'b1;
            sleepTimer_reg <= {SLEEP_WIDTH{1'b0}};
          end
        end else begin
          sleepTimer_reg <= sleepTimerInc[SLEEP_WIDTH-1:0];
        end
      end
    end
  end

  // Event pulses for the interrupt status register
  wire evRise = active_reg & ~activeDly_reg;
  wire evFall = ~active_reg & activeDly_reg;
  wire evSleep = sleep_reg & ~sleepDly_reg;
  wire evWake = ~sleep_reg & sleepDly_reg;
  wire [`OTD_IRQ_WIDTH-1:0] irqEvents = {evWake, evSleep, evFall, evRise};

  // Write-one-to-clear; a new event in the clearing cycle survives
  reg [`OTD_IRQ_WIDTH-1:0] irqClear;
  always @* begin
    irqClear = {`OTD_IRQ_WIDTH{1'b0}};
    if (wrPending_reg && (wrIndex_reg == `OTD_IDX_IRQ_STAT)) begin
      irqClear = hwdata[`OTD_IRQ_WIDTH-1:0];
    end
    irqStat_next = (irqStat_reg & ~irqClear) | irqEvents;
  end

  always @(posedge clk) begin
    if (rst) begin
      activeDly_reg <= 1'b0;
      sleepDly_reg <= 1'b0;
      irqStat_reg <= `OTD_RST_IRQ;
      irq_reg <= 1'b0;
      pinOne_reg <= 1'b0;
      pinTwo_reg <= 1'b0;
    end else begin
      activeDly_reg <= active_reg;
      sleepDly_reg <= sleep_reg;
      irqStat_reg <= irqStat_next;
      irq_reg <= |(irqStat_next & irqMask_reg);
      pinOne_reg <= active_reg & config_reg[`OTD_CFG_PIN_ONE];
      pinTwo_reg <= active_reg & config_reg[`OTD_CFG_PIN_TWO];
    end
  end

  // Status byte is assembled from live state; the unused bit reads zero
  wire [7:0] statusByte = {active_reg, 1'b0,
                           axisFlag[2], axisPolarity[2],
                           axisFlag[1], axisPolarity[1],
                           axisFlag[0], axisPolarity[0]};

  // Bus address phase: word-aligned addresses inside the first 1 KiB map to indices
  wire addrPhase = hsel & hready & htrans[1];
  wire addrInRange = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'b00);
  wire [7:0] addrIndex = addrInRange ? haddr[9:2] : 8'hff;

  function [31:0] readValue;
    input [7:0] index;
    begin
      case (index)
        `OTD_IDX_STATUS: readValue = {24'h00_0000, statusByte};
        `OTD_IDX_CONFIG: readValue = {{(32-`OTD_CFG_WIDTH){1'b0}}, config_reg};
        `OTD_IDX_UPPER: readValue = {{(32-DATA_WIDTH){1'b0}}, upperThreshold_reg};
        `OTD_IDX_LOWER: readValue = {{(32-DATA_WIDTH){1'b0}}, lowerThreshold_reg};
        `OTD_IDX_DEBOUNCE: readValue = {{(32-DB_WIDTH){1'b0}}, debounce_reg};
        `OTD_IDX_SLEEP: readValue = {{(32-SLEEP_WIDTH){1'b0}}, sleepCount_reg};
        `OTD_IDX_IRQ_STAT: readValue = {{(32-`OTD_IRQ_WIDTH){1'b0}}, irqStat_reg};
        `OTD_IDX_IRQ_MASK: readValue = {{(32-`OTD_IRQ_WIDTH){1'b0}}, irqMask_reg};
        default: readValue = 32'h0000_0000;
      endcase
    end
  endfunction

  // Zero-wait slave: read data is captured at the address phase edge and held in the data phase
  always @(posedge clk) begin
    if (rst) begin
      wrPending_reg <= 1'b0;
      wrIndex_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      wrPending_reg <= addrPhase & hwrite;
      if (addrPhase) begin
        wrIndex_reg <= addrIndex;
        if (!hwrite) begin
          hrdata_reg <= readValue(addrIndex);
        end
      end
    end
  end

  // Data phase writes; the status register has no write path
  always @(posedge clk) begin
    if (rst) begin
      config_reg <= `OTD_RST_CONFIG;
      upperThreshold_reg <= `OTD_RST_UPPER;
      lowerThreshold_reg <= `OTD_RST_LOWER;
      debounce_reg <= `OTD_RST_DEBOUNCE;
      sleepCount_reg <= `OTD_RST_SLEEP;
      irqMask_reg <= `OTD_RST_IRQ;
    end else if (wrPending_reg) begin
      case (wrIndex_reg)
        `OTD_IDX_CONFIG: config_reg <= hwdata[`OTD_CFG_WIDTH-1:0];
        `OTD_IDX_UPPER: upperThreshold_reg <= hwdata[DATA_WIDTH-1:0];
        `OTD_IDX_LOWER: lowerThreshold_reg <= hwdata[DATA_WIDTH-1:0];
        `OTD_IDX_DEBOUNCE: debounce_reg <= hwdata[DB_WIDTH-1:0];
        `OTD_IDX_SLEEP: sleepCount_reg <= hwdata[SLEEP_WIDTH-1:0];
        `OTD_IDX_IRQ_MASK: irqMask_reg <= hwdata[`OTD_IRQ_WIDTH-1:0];
        default: config_reg <= config_reg;
      endcase
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign outsideEventActive = active_reg;
  assign interruptPinOne = pinOne_reg;
  assign interruptPinTwo = pinTwo_reg;
  assign sleepMode = sleep_reg;
  assign irq = irq_reg;

endmodule // otd_outside_detect

`default_nettype wire

// [bench/otd_outside_checker.sv]
// Port-level assertions for the outside-threshold detector
`timescale 1ns/10ps
`default_nettype none

module otd_outside_checker (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Watched ports
  input wire odrTick,
  input wire outsideEventActive,
  input wire interruptPinOne,
  input wire interruptPinTwo,
  input wire sleepMode,
  input wire irq,
  input wire hreadyout,
  input wire hresp
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // The first edge after reset still compares against pre-reset values, hence the rst guard
  active_on_tick_a: assert property ($changed(outsideEventActive) && !$past(rst) |-> $past(odrTick))
    else $error("event-active changed without a sample");
  reset_clear_a: assert property ($fell(rst) |-> !outsideEventActive && !irq && !sleepMode)
    else $error("outputs not cleared by reset");
  pin_one_a: assert property (interruptPinOne |-> $past(outsideEventActive))
    else $error("pin one high without event-active");
  pin_two_a: assert property (interruptPinTwo |-> $past(outsideEventActive))
    else $error("pin two high without event-active");
  pin_fall_a: assert property ($fell(outsideEventActive) |=> !interruptPinOne && !interruptPinTwo)
    else $error("pins stayed high after event-active fell");
  sleep_block_a: assert property ($rose(sleepMode) |-> !$past(outsideEventActive))
    else $error("sleep entered while event-active");
  sleep_on_tick_a: assert property ($changed(sleepMode) && !$past(rst) |-> $past(odrTick))
    else $error("sleep state changed without a sample");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
endmodule // otd_outside_checker

bind otd_outside_detect otd_outside_checker chk (.clk(clk), .rst(rst), .odrTick(odrTick),
  .outsideEventActive(outsideEventActive), .interruptPinOne(interruptPinOne),
  .interruptPinTwo(interruptPinTwo), .sleepMode(sleepMode), .irq(irq),
  .hreadyout(hreadyout), .hresp(hresp));
`default_nettype wire

// [bench/otd_host_model.sv]
// Host-side model that counts interrupt requests on the two event pins
`timescale 1ns/10ps
`default_nettype none

module otd_host_model (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Interrupt pins from the device
  input wire interruptPinOne,
  input wire interruptPinTwo,
  // Request counts
  output logic [7:0] pinOneRises,
  output logic [7:0] pinTwoRises
);
  logic pinOneLast = 1'b0;
  logic pinTwoLast = 1'b0;

  // Edge counting keeps a stuck-high pin from looking like many requests
  always @(posedge clk) begin
    if (rst) begin
      pinOneRises <= 8'h00;
      pinTwoRises <= 8'h00;
    end else begin
      pinOneRises <= pinOneRises + 8'(interruptPinOne && !pinOneLast);
      pinTwoRises <= pinTwoRises + 8'(interruptPinTwo && !pinTwoLast);
    end
    pinOneLast <= interruptPinOne;
    pinTwoLast <= interruptPinTwo;
  end
endmodule // otd_host_model
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the outside-threshold detector
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic odrTick = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic rdStrobe = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [11:0] xSample = 12'h000;
  logic [11:0] ySample = 12'h000;
  logic [11:0] zSample = 12'h000;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] seed = 32'h0000_0015;
  logic [31:0] expQ [$];
  wire hreadyout, hresp, outsideEventActive, interruptPinOne, interruptPinTwo, sleepMode, irq;
  wire [31:0] hrdata;
  wire [7:0] pinOneRises, pinTwoRises;
  int miscompares = 0;
  int totalChecks = 0;
  logic [7:0] regAddr [9] = '{8'hb4, 8'hc0, 8'hc4, 8'hc8, 8'hcc, 8'hd0, 8'hd4, 8'hd8, 8'hb6};
  logic [31:0] regRst [9] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_07ff, 32'h0000_0800,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  logic [11:0] yVal [5] = '{12'h063, 12'hf9d, 12'hf9c, 12'h000, 12'h064};
  logic [31:0] yExp [5] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0088, 32'h0000_0000, 32'h0000_008c};

  always #10 clk = ~clk;

  otd_outside_detect uut (.clk(clk), .rst(rst), .odrTick(odrTick), .xSample(xSample), .ySample(ySample),
    .zSample(zSample), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .outsideEventActive(outsideEventActive), .interruptPinOne(interruptPinOne),
    .interruptPinTwo(interruptPinTwo), .sleepMode(sleepMode), .irq(irq));
  otd_host_model host (.clk(clk), .rst(rst), .interruptPinOne(interruptPinOne),
    .interruptPinTwo(interruptPinTwo), .pinOneRises(pinOneRises), .pinTwoRises(pinTwoRises));

  function automatic logic [11:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[11:0];
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Read data is noted here and compared by the monitor at the data-phase edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0000_0000;
    rdStrobe <= !w;
    if (!w)
      expQ.push_back(d);
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdStrobe <= 1'b0;
  endtask

  // Samples are scrambled outside the strobe so stale values cannot pass
  task automatic tick(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
    @(posedge clk);
    odrTick <= 1'b1;
    xSample <= x;
    ySample <= y;
    zSample <= z;
    @(posedge clk);
    odrTick <= 1'b0;
    xSample <= ~x;
    ySample <= rnd();
    zSample <= ~z;
  endtask

  task automatic resetDut();
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  always @(posedge clk) begin
    if (rdStrobe === 1'b1 && hreadyout === 1'b1)
      check(hrdata, expQ.pop_front());
  end

  initial begin
    #500_000;
    miscompares++;
    reportAndStop();
  end

  initial begin
    resetDut();
    for (int i = 0; i < 9; i++)
      bus(1'b0, regAddr[i], regRst[i]);
    bus(1'b1, 8'hb4, 32'h0000_00ff);
    bus(1'b0, 8'hb4, 32'h0000_0000);
    $display("test 1 done");
    bus(1'b1, 8'hc0, 32'h0000_0021);
    bus(1'b1, 8'hc4, 32'h0000_0064);
    bus(1'b1, 8'hc8, 32'h0000_0f9c);
    bus(1'b1, 8'hcc, 32'h0000_0003);
    bus(1'b1, 8'hd8, 32'h0000_0001);
    tick(12'h064, rnd(), rnd());
    bus(1'b0, 8'hb4, 32'h0000_0030);
    tick(12'h000, rnd(), rnd());
    bus(1'b0, 8'hb4, 32'h0000_0010);
    tick(12'hf9c, rnd(), rnd());
    tick(12'hf9c, rnd(), rnd());
    bus(1'b0, 8'hb4, 32'h0000_0020);
    tick(12'hf9c, rnd(), 12'h000);
    bus(1'b0, 8'hb4, 32'h0000_00a0);
    settle();
    check(32'(interruptPinOne), 32'h0000_0001);
    check(32'(interruptPinTwo), 32'h0000_0000);
    check(32'(irq), 32'h0000_0001);
    bus(1'b0, 8'hd4, 32'h0000_0001);
    bus(1'b1, 8'hd4, 32'h0000_0001);
    settle();
    check(32'(irq), 32'h0000_0000);
    check(32'(pinOneRises), 32'h0000_0001);
    $display("test 2 done");
    bus(1'b1, 8'hc0, 32'h0000_000c);
    bus(1'b1, 8'hcc, 32'h0000_0000);
    tick(rnd(), rnd(), 12'h1f4);
    bus(1'b0, 8'hb4, 32'h0000_0083);
    tick(rnd(), rnd(), 12'h1f4);
    bus(1'b0, 8'hb4, 32'h0000_0001);
    $display("test 3 done");
    resetDut();
    bus(1'b1, 8'hc0, 32'h0000_0002);
    bus(1'b1, 8'hc4, 32'h0000_0064);
    bus(1'b1, 8'hc8, 32'h0000_0f9c);
    for (int i = 0; i < 5; i++) begin
      tick(rnd(), yVal[i], rnd());
      bus(1'b0, 8'hb4, yExp[i]);
    end
    $display("test 4 done");
    bus(1'b1, 8'hd0, 32'h0000_0004);
    repeat (5) tick(rnd(), 12'h000, rnd());
    settle();
    check(32'(sleepMode), 32'h0000_0001);
    bus(1'b1, 8'hc0, 32'h0000_0051);
    repeat (6) tick(12'h064, rnd(), rnd());
    settle();
    check(32'(sleepMode), 32'h0000_0000);
    check(32'(outsideEventActive), 32'h0000_0001);
    check(32'(interruptPinTwo), 32'h0000_0001);
    check(32'(interruptPinOne), 32'h0000_0000);
    repeat (2) tick(12'h000, rnd(), rnd());
    settle();
    check(32'(sleepMode), 32'h0000_0000);
    check(32'(interruptPinTwo), 32'h0000_0000);
    check(32'(pinTwoRises), 32'h0000_0001);
    check(32'(hresp), 32'h0000_0000);
    // Rise, fall, sleep entry and sleep exit have all happened since the last reset
    bus(1'b0, 8'hd4, 32'h0000_000f);
    $display("test 5 done");
    reportAndStop();
  end
endmodule // testbench
`default_nettype wire
